// >>> hw/ioxe_core.v
`timescale 1ns/1ps
// Notes on behaviour
// - Indexed add sums accumulator and byte at pointer plus offset; updates five flags.
// - Destination bit clear writes the accumulator; set writes the indexed byte.
// - Indexed bit set forces one chosen bit of the indexed byte; flags untouched.
// - Offset 0..95 from low bits is added to the index base pointer.
// - Branch if not negative adds twice the operand to PC+2; taken costs one idle cycle.
`include "ioxe_regs.vh"

module ioxe_core (
   input wire clk_in,
   input wire reset_in,
   input wire instr_valid_in,
   input wire [15:0] instr_in,
   input wire [11:0] index_base_pointer_in,
   input wire [20:0] pc_in,
   input wire [7:0] acc_in,
   input wire [4:0] status_in,
   input wire [11:0] dbg_addr_in,
   output reg instr_ready_out,
   output reg acc_we_out,
   output reg [7:0] acc_out,
   output reg status_we_out,
   output reg [4:0] status_out,
   output reg pc_we_out,
   output reg [20:0] pc_out,
   output reg mem_we_out,
   output reg [11:0] mem_addr_out,
   output reg [7:0] mem_data_out,
   output reg illegal_out,
   output reg [7:0] dbg_data_out
);
   // ------------------------------------------------------------
   // Phase counter and decode
   // ------------------------------------------------------------
   localparam ST_IDLE = 2'h0;
   localparam ST_EXEC = 2'h1;
   localparam ST_FLUSH = 2'h2;

   reg [1:0] state_q;
   reg [1:0] phase_q;
   reg [15:0] ir_q;
   reg [11:0] ea_q;
   wire [7:0] rd_data;
   reg [7:0] rd_data_q;
   wire [7:0] dbg_rd;


   // Decode works on the latched word only, so a new word offered
   // while busy cannot disturb the instruction in flight.
   // Bit 8 must be clear for the indexed forms; otherwise the word
   // belongs to another group and ends up flagged as illegal.
   wire is_add = (ir_q[15:10] == `IOXE_OP_ADD_HI) && !ir_q[8];
   wire is_bset = (ir_q[15:12] == `IOXE_OP_BSET_HI) && !ir_q[8];
   wire is_fill = (ir_q[15:8] == `IOXE_OP_FILL_HI);
   wire is_brpos = (ir_q[15:8] == `IOXE_OP_BRPOS_HI);
   wire [6:0] offset = ir_q[6:0];
   wire off_bad = (offset > `IOXE_OFFSET_MAX) || ir_q[7];
   // Offsets above the legal range still address memory; they are
   // only reported, since software must never issue them.

   // ------------------------------------------------------------
   // Effective address
   // ------------------------------------------------------------
   // Formed from the live word at the take edge, so the operand is
   // already on its way out of the registered read port in Q2
   wire [11:0] ea_d = index_base_pointer_in + {5'h00, instr_in[6:0]};

   // ------------------------------------------------------------
   // Operand arithmetic
   // ------------------------------------------------------------
   // The accumulator is read live in Q4; the partner holds it steady
   // while the sequencer is busy.
   // Arithmetic of the indexed add, bit mask and branch target
   wire [8:0] full_sum = {1'b0, acc_in} + {1'b0, rd_data_q};
   wire [4:0] low_sum = {1'b0, acc_in[3:0]} + {1'b0, rd_data_q[3:0]};
   wire ov_d = (acc_in[7] == rd_data_q[7]) && (full_sum[7] != acc_in[7]);
   wire [7:0] bit_mask = 8'h01 << ir_q[11:9];
   wire [20:0] pc_inc = pc_in + 21'h000002;
   wire [20:0] br_target = pc_inc + {{12{ir_q[7]}}, ir_q[7:0], 1'b0};

   // ------------------------------------------------------------
   // Data memory and debug mirror
   // ------------------------------------------------------------
   // The mirror costs a second array but leaves the operand port free,
   // so debug reads never steal a cycle from execution.
   ioxe_data_mem u_mem (
      .clk_in(clk_in),
      .rd_addr_in(ea_q),
      .rd_data_out(rd_data),
      .wr_en_in(mem_we_out),
      .wr_addr_in(mem_addr_out),
      .wr_data_in(mem_data_out)
   );

   ioxe_data_mem u_dbg_mirror (
      .clk_in(clk_in),
      .rd_addr_in(dbg_addr_in),
      .rd_data_out(dbg_rd),
      .wr_en_in(mem_we_out),
      .wr_addr_in(mem_addr_out),
      .wr_data_in(mem_data_out)
   );

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         state_q <= ST_IDLE;
         phase_q <= `IOXE_PH_Q1;
         ir_q <= 16'h0000;
         ea_q <= 12'h000;
         rd_data_q <= 8'h00;
         instr_ready_out <= 1'b1;
         acc_we_out <= 1'b0;
         acc_out <= 8'h00;
         status_we_out <= 1'b0;
         status_out <= `IOXE_STATUS_RESET;
         pc_we_out <= 1'b0;
         pc_out <= 21'h000000;
         mem_we_out <= 1'b0;
         mem_addr_out <= 12'h000;
         mem_data_out <= 8'h00;
         illegal_out <= 1'b0;
         dbg_data_out <= 8'h00;
      end else begin
         acc_we_out <= 1'b0;
         status_we_out <= 1'b0;
         pc_we_out <= 1'b0;
         mem_we_out <= 1'b0;
         illegal_out <= 1'b0;
         dbg_data_out <= dbg_rd;
         case (state_q)
            ST_IDLE: begin
               if (instr_valid_in) begin
                  ir_q <= instr_in;
                  ea_q <= ea_d;
                  phase_q <= `IOXE_PH_Q2;
                  instr_ready_out <= 1'b0;
                  state_q <= ST_EXEC;
               end
            end
            ST_EXEC: begin
               phase_q <= phase_q + 2'h1;
               case (phase_q)
                  `IOXE_PH_Q2: begin
                     if (is_add || is_bset || is_fill) begin
                        illegal_out <= off_bad;
                     end
                  end
                  `IOXE_PH_Q3: begin
                     rd_data_q <= rd_data;
                  end
                  default: begin
                     // Q4: write to the destination
                     instr_ready_out <= 1'b1;
                     state_q <= ST_IDLE;
                     phase_q <= `IOXE_PH_Q1;
                     // Strobes last one cycle; data outputs hold until the next write
                     if (is_add) begin
                        status_we_out <= 1'b1;
                        status_out[`IOXE_FLAG_C] <= full_sum[8];
                        status_out[`IOXE_FLAG_DIGIT_CARRY] <= low_sum[4];
                        status_out[`IOXE_FLAG_Z] <= (full_sum[7:0] == 8'h00);
                        status_out[`IOXE_FLAG_OVERFLOW] <= ov_d;
                        status_out[`IOXE_FLAG_N] <= full_sum[7];
                        if (ir_q[`IOXE_DEST_BIT]) begin
                           mem_we_out <= 1'b1;
                           mem_addr_out <= ea_q;
                           mem_data_out <= full_sum[7:0];
                        end else begin
                           acc_we_out <= 1'b1;
                           acc_out <= full_sum[7:0];
                        end
                     end else if (is_bset) begin
                        mem_we_out <= 1'b1;
                        mem_addr_out <= ea_q;
                        mem_data_out <= rd_data_q | bit_mask;
                     end else if (is_fill) begin
                        mem_we_out <= 1'b1;
                        mem_addr_out <= ea_q;
                        mem_data_out <= `IOXE_ALL_ONES;
                     end else if (is_brpos && !status_in[`IOXE_FLAG_N]) begin
                        // Taken branch: the next word was fetched from the old
                        // flow, so one whole idle instruction cycle follows
                        pc_we_out <= 1'b1;
                        pc_out <= br_target;
                        instr_ready_out <= 1'b0;
                        state_q <= ST_FLUSH;
                     end else if (!is_brpos) begin
                        illegal_out <= 1'b1;
                     end
                  end
               endcase
            end
            ST_FLUSH: begin
               // Idle cycle of a taken branch
               phase_q <= phase_q + 2'h1;
               if (phase_q == `IOXE_PH_Q4) begin
                  instr_ready_out <= 1'b1;
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
               instr_ready_out <= 1'b1;
            end
         endcase
      end
   end
endmodule // ioxe_core

// >>> hw/ioxe_data_mem.v
`timescale 1ns/1ps
// ------------------------------------------------------------
// Byte-wide data memory, registered read
// ------------------------------------------------------------
module ioxe_data_mem (
   input wire clk_in,
   input wire [11:0] rd_addr_in,
   output reg [7:0] rd_data_out,
   input wire wr_en_in,
   input wire [11:0] wr_addr_in,
   input wire [7:0] wr_data_in
);
   reg [7:0] mem_q [0:4095];

   always @(posedge clk_in) begin
      if (wr_en_in) begin
         mem_q[wr_addr_in] <= wr_data_in;
      end
      rd_data_out <= mem_q[rd_addr_in];
   end
endmodule // ioxe_data_mem

// >>> hw/ioxe_regs.vh
`ifndef IOXE_REGS_VH
`define IOXE_REGS_VH

// ------------------------------------------------------------
// Opcode fields
// ------------------------------------------------------------
`define IOXE_OP_ADD_HI 6'h09
`define IOXE_OP_BSET_HI 4'h8
`define IOXE_OP_FILL_HI 8'h68
`define IOXE_OP_BRPOS_HI 8'hE7
`define IOXE_OFFSET_MAX 7'h5F
`define IOXE_DEST_BIT 9
`define IOXE_ALL_ONES 8'hFF

// ------------------------------------------------------------
// Flag positions in the status byte
// ------------------------------------------------------------
`define IOXE_FLAG_C 0
`define IOXE_FLAG_DIGIT_CARRY 1
`define IOXE_FLAG_Z 2
`define IOXE_FLAG_OVERFLOW 3
`define IOXE_FLAG_N 4
`define IOXE_STATUS_RESET 5'h00

// ------------------------------------------------------------
// Phases of one instruction cycle
// ------------------------------------------------------------
`define IOXE_PHASES 4
`define IOXE_PH_Q1 2'h0
`define IOXE_PH_Q2 2'h1
`define IOXE_PH_Q3 2'h2
`define IOXE_PH_Q4 2'h3

`endif

// >>> tb/indexed_offset_exec_tb_top.sv
`timescale 1ns/1ps
module indexed_offset_exec_tb_top;
   logic clk_in = 0, reset_in = 1, vld = 0, ld = 0;
   logic [15:0] ins = 16'h0000;
   logic [11:0] base = 12'h000, dba = 12'h000;
   logic [20:0] pc_in = 21'h0, cyc, c0, v_pc;
   logic [7:0] ld_acc = 8'h00, acc_in, acc_o, mem_d, dbg_d, v_acc, v_mem;
   logic [4:0] st_in, st_o, v_st;
   logic [11:0] mem_a, v_adr;
   logic rdy, acc_we, st_we, pc_we, mem_we, ill, s_acc, s_st, s_pc, s_mem, s_ill;
   logic [31:0] seed = 32'h00011DF9;
   int errors = 0, comparisons = 0;
   wire [20:0] v_pc_w;
   initial forever #12.5 clk_in = ~clk_in;
   ioxe_core dut_u (.clk_in(clk_in), .reset_in(reset_in), .instr_valid_in(vld),
      .instr_in(ins), .index_base_pointer_in(base), .pc_in(pc_in), .acc_in(acc_in),
      .status_in(st_in), .dbg_addr_in(dba), .instr_ready_out(rdy), .acc_we_out(acc_we),
      .acc_out(acc_o), .status_we_out(st_we), .status_out(st_o), .pc_we_out(pc_we),
      .pc_out(v_pc_w), .mem_we_out(mem_we), .mem_addr_out(mem_a), .mem_data_out(mem_d),
      .illegal_out(ill), .dbg_data_out(dbg_d));
   ioxe_partner p_u (.clk_in(clk_in), .reset_in(reset_in), .ld_in(ld), .ld_acc_in(ld_acc),
      .acc_we_in(acc_we), .acc_d_in(acc_o), .status_we_in(st_we), .status_d_in(st_o),
      .acc_out(acc_in), .status_out(st_in));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [4:0] fl(input logic [7:0] a, m);
      logic [8:0] s;
      s = a + m;
      return {s[7], a[7] == m[7] && s[7] != a[7], s[7:0] == 8'h00,
         (a[3:0] + m[3:0]) > 5'h0F, s[8]};
   endfunction
   task chk(input string nm, input logic [20:0] got, exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s exp %h got %h", nm, exp, got);
      end
   endtask
   task report_and_stop;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Fixed 12-cycle window catches strobes whether they land with or before ready
   task exec(input logic [15:0] op);
      {s_acc, s_st, s_pc, s_mem, s_ill} = 5'h00;
      cyc = 21'h0;
      vld <= 1'b1;
      ins <= op;
      @(posedge clk_in) vld <= 1'b0;
      repeat (12) begin
         @(negedge clk_in);
         cyc += !rdy;
         if (acc_we) {s_acc, v_acc} = {1'b1, acc_o};
         if (st_we) {s_st, v_st} = {1'b1, st_o};
         if (pc_we) {s_pc, v_pc} = {1'b1, v_pc_w};
         if (mem_we) {s_mem, v_mem, v_adr} = {1'b1, mem_d, mem_a};
         s_ill |= ill;
      end
      @(posedge clk_in);
   endtask
   initial begin
      repeat (20000) @(posedge clk_in);
      errors++;
      report_and_stop;
   end
   initial begin
      logic [31:0] r;
      logic [7:0] a, s, n, e;
      logic [6:0] k;
      logic [4:0] f;
      repeat (12) @(posedge clk_in);
      reset_in <= 1'b0;
      for (int i = 0; i < 30; i++) begin
         r = rnd();
         k = (i == 0) ? 7'h5F : r[18:12] % 7'h60;
         a = r[26:19];
         {base, ld_acc, ld, pc_in} <= {r[11:0], a, 1'b1, r[20:0] & 21'h1FFFFE};
         @(posedge clk_in) ld <= 1'b0;
         exec({8'h68, 1'b0, k});
         if (i == 0) c0 = cyc;
         chk("fill", {s_st, s_mem, v_mem}, {2'b01, 8'hFF});
         chk("adr", v_adr, 12'(base + k));
         exec({6'h09, 3'b100, k});
         s = a + 8'hFF;
         chk("add_m", {s_acc, v_mem, v_st}, {1'b0, s, fl(a, 8'hFF)});
         exec({6'h09, 3'b000, k});
         f = fl(a, s);
         chk("add_a", {s_mem, v_acc, v_st}, {1'b0, 8'(a + s), f});
         exec({4'h8, r[2:0], 2'b00, k});
         e = s | (8'h01 << r[2:0]);
         chk("bset", {s_st, v_mem}, {1'b0, e});
         dba <= 12'(base + k);
         repeat (3) @(negedge clk_in);
         chk("dbg", dbg_d, e);
         @(posedge clk_in);
         n = r[30:23];
         exec({8'hE7, n});
         chk("br_we", s_pc, !f[4]);
         if (!f[4]) chk("br_pc", v_pc, pc_in + 21'h2 + {{12{n[7]}}, n, 1'b0});
         chk("br_cyc", cyc, f[4] ? c0 : c0 + 21'h4);
      end
      exec({8'h68, 8'h60});
      chk("ill", {s_ill, s_mem}, 2'b11);
      report_and_stop;
   end
endmodule // indexed_offset_exec_tb_top

// >>> tb/ioxe_core_asserts.sv
`timescale 1ns/1ps
module ioxe_chk (
   input wire clk_in,
   input wire reset_in,
   input wire instr_valid_in,
   input wire [15:0] instr_in,
   input wire [11:0] index_base_pointer_in,
   input wire [20:0] pc_in,
   input wire instr_ready_out,
   input wire acc_we_out,
   input wire status_we_out,
   input wire pc_we_out,
   input wire [20:0] pc_out,
   input wire mem_we_out,
   input wire [11:0] mem_addr_out,
   input wire [7:0] mem_data_out
);
   reg [15:0] op_q;
   reg [11:0] base_q;
   reg [20:0] pc_q;
   always @(posedge clk_in) begin
      if (instr_valid_in && instr_ready_out) begin
         op_q <= instr_in;
         base_q <= index_base_pointer_in;
         pc_q <= pc_in;
      end
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);
   property p_st; status_we_out |-> op_q[15:10] == 6'h09; endproperty
   property p_dst; acc_we_out |-> !mem_we_out && !op_q[9]; endproperty
   property p_bst; mem_we_out && op_q[15:12] == 4'h8 |-> !status_we_out; endproperty
   property p_adr; mem_we_out |-> mem_addr_out == base_q + {4'h0, op_q[7:0]}; endproperty
   property p_fil;
      mem_we_out && op_q[15:8] == 8'h68 |-> mem_data_out == 8'hFF && !status_we_out;
   endproperty
   property p_br;
      pc_we_out |-> pc_out == pc_q + 21'h2 + {{12{op_q[7]}}, op_q[7:0], 1'b0};
   endproperty
   property p_bsy; $fell(instr_ready_out) |-> ##[2:8] instr_ready_out; endproperty
   a_st: assert property (p_st) else $error("flag write outside add");
   a_dst: assert property (p_dst) else $error("bad add destination");
   a_bst: assert property (p_bst) else $error("bit set wrote flags");
   a_adr: assert property (p_adr) else $error("bad indexed address");
   a_fil: assert property (p_fil) else $error("bad fill write");
   a_br: assert property (p_br) else $error("bad branch target");
   a_bsy: assert property (p_bsy) else $error("busy too long");
   c_add: cover property (status_we_out);
   c_br: cover property (pc_we_out);
   c_fil: cover property (mem_we_out && op_q[15:8] == 8'h68);
endmodule // ioxe_chk
bind ioxe_core ioxe_chk chk_u (.clk_in(clk_in), .reset_in(reset_in),
   .instr_valid_in(instr_valid_in), .instr_in(instr_in),
   .index_base_pointer_in(index_base_pointer_in), .pc_in(pc_in),
   .instr_ready_out(instr_ready_out), .acc_we_out(acc_we_out),
   .status_we_out(status_we_out), .pc_we_out(pc_we_out), .pc_out(pc_out),
   .mem_we_out(mem_we_out), .mem_addr_out(mem_addr_out), .mem_data_out(mem_data_out));

// >>> tb/ioxe_partner.sv
`timescale 1ns/1ps
module ioxe_partner (
   input wire clk_in,
   input wire reset_in,
   input wire ld_in,
   input wire [7:0] ld_acc_in,
   input wire acc_we_in,
   input wire [7:0] acc_d_in,
   input wire status_we_in,
   input wire [4:0] status_d_in,
   output logic [7:0] acc_out,
   output logic [4:0] status_out
);
   always @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         acc_out <= 8'h00;
         status_out <= 5'h00;
      end else begin
         // Bench preload wins so each pass starts from a known accumulator
         if (ld_in) acc_out <= ld_acc_in;
         else if (acc_we_in) acc_out <= acc_d_in;
         if (status_we_in) status_out <= status_d_in;
      end
   end
endmodule // ioxe_partner
